//--- fpe_defines.svh
// register offsets, field positions, reset values and timing figures
`ifndef FPE_DEFINES_SVH
`define FPE_DEFINES_SVH

// register byte offsets on the bus
`define FPE_OFS_ADDR        12'h000
`define FPE_OFS_DATA        12'h004
`define FPE_OFS_CTRL        12'h008
`define FPE_OFS_STAT        12'h00c
`define FPE_OFS_MASK        12'h010

// field positions
`define FPE_ADDR_MSB        14
`define FPE_KEY_MSB         31
`define FPE_KEY_LSB         16
`define FPE_CMD_PROG        0
`define FPE_CMD_PERASE      1
`define FPE_CMD_MASS        2
`define FPE_CMD_COMMIT      3
`define FPE_ST_ACCESS       0
`define FPE_ST_PROG         1

// values
`define FPE_WRITE_KEY       16'ha442
`define FPE_RST_WORD        32'h0000_0000
`define FPE_WORD_ALIGN_B    2
`define FPE_PAGE_ALIGN_B    10

// timing: longest operation times in microseconds, clock in hertz
`define FPE_SYS_CLK_HZ      40000000
`define FPE_PROG_TIME_US    50
`define FPE_PERASE_TIME_US  25000
`define FPE_MASS_TIME_US    250000
`define FPE_COMMIT_TIME_US  50
`define FPE_US_CYCLES       (`FPE_SYS_CLK_HZ / 1000000)

`endif

//--- fpe_pkg.sv
// types shared by the flash program and erase controller
package fpe_pkg;
    // sequencer states, one-hot
    typedef enum logic [1:0] {
        FPE_IDLE = 2'b01,
        FPE_RUN  = 2'b10
    } fpe_state_e;
    // one bit per command: program, page erase, mass erase, commit
    typedef logic [3:0] fpe_cmd_t;
endpackage : fpe_pkg

//--- fpe_usec_tick.sv
// microsecond tick divider reloaded from the tick reload value
`timescale 1ns/10ps
module fpe_usec_tick (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       run,
    input  wire logic [7:0] reload,
    output logic            tick
);
    import fpe_pkg::*;

    logic [7:0] div_r;   // cycles left in this microsecond
    logic [7:0] div_nxt;

    // count down; restart from reload so each tick is reload+1 cycles
    always_comb begin
        if (!run || div_r == 8'h00) begin
            div_nxt = reload;
        end else begin
            div_nxt = div_r - 8'h01;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_nxt;
        end
    end

    // tick only while an operation runs, so the first interval is whole
    assign tick = run && (div_r == 8'h00);
endmodule : fpe_usec_tick

//--- fpe_op_timer.sv
// counts microsecond ticks for the length of one flash operation
`timescale 1ns/10ps
module fpe_op_timer #(
    parameter int CNT_W = 18
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] dur_us,
    input  wire logic             tick,
    output logic                  done
);
    import fpe_pkg::*;

    logic [CNT_W-1:0] cnt_r;  // microseconds still to run
    logic [CNT_W-1:0] cnt_nxt;
    logic             run_r;  // timer active
    logic             run_nxt;

    // load on start, count on tick, finish when the last tick arrives
    always_comb begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        done    = 1'b0;
        if (start) begin
            cnt_nxt = dur_us;
            run_nxt = 1'b1;
        end else if (run_r && tick) begin
            if (cnt_r <= CNT_W'(1)) begin
                done    = 1'b1;
                run_nxt = 1'b0;
                cnt_nxt = '0;
            end else begin
                cnt_nxt = cnt_r - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_r <= '0;
            run_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
        end
    end

    // a done pulse never comes from an idle timer
    done_needs_run_a: assert property (@(posedge sys_clk) disable iff (reset)
        done |-> run_r)
        else $error("timer finished while not running");
endmodule : fpe_op_timer

//--- fpe_flash_ctrl.sv
// register front end and sequencer of the flash program/erase controller
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/10ps
`include "fpe_defines.svh"
module fpe_flash_ctrl #(
    parameter int PROG_US   = `FPE_PROG_TIME_US,
    parameter int PERASE_US = `FPE_PERASE_TIME_US,
    parameter int MASS_US   = `FPE_MASS_TIME_US,
    parameter int COMMIT_US = `FPE_COMMIT_TIME_US
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [7:0]  microsecond_tick_reload,
    input  wire logic        access_violation,
    input  wire logic        exec_only_read,
    output fpe_pkg::fpe_cmd_t flash_op_sel,
    output logic             flash_op_start,
    output logic      [14:0] flash_op_addr,
    output logic      [31:0] flash_op_data,
    output logic             flash_busy,
    output logic             program_done_raw_flag,
    output logic             irq
);
    import fpe_pkg::*;

    localparam int CNT_W = 18;  // wide enough for the mass erase time

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------

    // true when the bus address selects the given register
    function automatic logic reg_hit(input logic [11:0] adr,
                                     input logic [11:0] ofs);
        reg_hit = (adr[11:2] == ofs[11:2]);
    endfunction : reg_hit

    // merge write data into a word under the byte enables
    function automatic logic [31:0] byte_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        byte_merge = res;
    endfunction : byte_merge

    // clear the low address bits that the operation does not use
    function automatic logic [14:0] align_down(input logic [14:0] a,
                                               input int          bits);
        align_down = a & ~((15'h0001 << bits) - 15'h0001);
    endfunction : align_down

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic             ack_r;        // bus answer, one cycle
    logic             ack_nxt;
    logic [31:0]      rdat_r;       // registered read data
    logic [31:0]      rdat_nxt;
    logic [14:0]      addr_r;       // flash_target_address offset
    logic [14:0]      addr_nxt;
    logic [31:0]      data_r;       // flash_write_data word
    logic [31:0]      data_nxt;
    fpe_cmd_t         cmd_r;        // running command bit, reads as busy
    fpe_cmd_t         cmd_nxt;
    fpe_state_e       state_r;      // sequencer state
    fpe_state_e       state_nxt;
    logic             start_r;      // operation launch pulse
    logic             start_nxt;
    logic [14:0]      op_addr_r;    // aligned address given to the array
    logic [14:0]      op_addr_nxt;
    logic [31:0]      op_data_r;    // word given to the array
    logic [31:0]      op_data_nxt;
    logic [1:0]       stat_r;       // flash_raw_irq_status sticky bits
    logic [1:0]       stat_nxt;
    logic [1:0]       mask_r;       // interrupt mask, same layout
    logic [1:0]       mask_nxt;
    logic [CNT_W-1:0] dur_us;       // length of the launched operation
    logic             tick;         // one microsecond elapsed
    logic             op_done;      // operation finished this cycle
    logic             acc;          // request accepted this edge
    logic             wr_acc;
    logic             rd_acc;
    logic             key_ok;       // write carries the key
    fpe_cmd_t         req_cmd;      // single command picked from a write

    // request is taken on the edge that the master sees ack high
    assign acc    = wb_cyc_i && wb_stb_i && ack_r;
    assign wr_acc = acc && wb_we_i;
    assign rd_acc = acc && !wb_we_i;
    assign key_ok = (wb_dat_i[`FPE_KEY_MSB:`FPE_KEY_LSB] == `FPE_WRITE_KEY)
                    && (wb_sel_i == 4'hf);

    // ---------------------------------------------------------------
    // bus slave: one wait state, then ack for one cycle
    // ---------------------------------------------------------------
    always_comb begin
        ack_nxt  = wb_cyc_i && wb_stb_i && !ack_r;
        rdat_nxt = rdat_r;
        if (ack_nxt) begin
            // unmapped offsets answer with zero
            rdat_nxt = `FPE_RST_WORD;
            if (reg_hit(wb_adr_i, `FPE_OFS_ADDR)) begin
                rdat_nxt[`FPE_ADDR_MSB:0] = addr_r;
            end else if (reg_hit(wb_adr_i, `FPE_OFS_DATA)) begin
                // execute-only blocks must not leak, so hide the word
                rdat_nxt = exec_only_read ? `FPE_RST_WORD : data_r;
            end else if (reg_hit(wb_adr_i, `FPE_OFS_CTRL)) begin
                rdat_nxt[3:0] = cmd_r;  // key field stays zero
            end else if (reg_hit(wb_adr_i, `FPE_OFS_STAT)) begin
                rdat_nxt[1:0] = stat_r;
            end else if (reg_hit(wb_adr_i, `FPE_OFS_MASK)) begin
                rdat_nxt[1:0] = mask_r;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ack_r  <= 1'b0;
            rdat_r <= `FPE_RST_WORD;
        end else begin
            ack_r  <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // ---------------------------------------------------------------
    // address, data and mask registers
    // ---------------------------------------------------------------
    always_comb begin
        logic [31:0] tmp;
        tmp      = byte_merge({17'h0, addr_r}, wb_dat_i, wb_sel_i);
        addr_nxt = addr_r;
        data_nxt = data_r;
        mask_nxt = mask_r;
        if (wr_acc && reg_hit(wb_adr_i, `FPE_OFS_ADDR)) begin
            addr_nxt = tmp[`FPE_ADDR_MSB:0];  // upper bits dropped
        end
        if (wr_acc && reg_hit(wb_adr_i, `FPE_OFS_DATA)) begin
            data_nxt = byte_merge(data_r, wb_dat_i, wb_sel_i);
        end
        if (wr_acc && reg_hit(wb_adr_i, `FPE_OFS_MASK) && wb_sel_i[0]) begin
            mask_nxt = wb_dat_i[1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            addr_r <= 15'h0000;
            data_r <= `FPE_RST_WORD;
            mask_r <= 2'h0;
        end else begin
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            mask_r <= mask_nxt;
        end
    end

    // ---------------------------------------------------------------
    // command sequencer
    // ---------------------------------------------------------------

    // several bits set is a software fault; lowest bit wins here
    always_comb begin
        req_cmd = '0;
        if (wb_dat_i[`FPE_CMD_PROG]) begin
            req_cmd[`FPE_CMD_PROG] = 1'b1;
        end else if (wb_dat_i[`FPE_CMD_PERASE]) begin
            req_cmd[`FPE_CMD_PERASE] = 1'b1;
        end else if (wb_dat_i[`FPE_CMD_MASS]) begin
            req_cmd[`FPE_CMD_MASS] = 1'b1;
        end else if (wb_dat_i[`FPE_CMD_COMMIT]) begin
            req_cmd[`FPE_CMD_COMMIT] = 1'b1;
        end
    end

    // duration of the launched command in microseconds
    always_comb begin
        unique case (1'b1)
            cmd_r[`FPE_CMD_PERASE]: dur_us = CNT_W'(PERASE_US);
            cmd_r[`FPE_CMD_MASS]:   dur_us = CNT_W'(MASS_US);
            cmd_r[`FPE_CMD_COMMIT]: dur_us = CNT_W'(COMMIT_US);
            default:                dur_us = CNT_W'(PROG_US);
        endcase
    end

    // idle takes a keyed write; run holds until the timer finishes
    always_comb begin
        state_nxt   = state_r;
        cmd_nxt     = cmd_r;
        start_nxt   = 1'b0;
        op_addr_nxt = op_addr_r;
        op_data_nxt = op_data_r;
        unique case (state_r)
            FPE_IDLE: begin
                // wrong key or no bit set leaves everything alone
                if (wr_acc && reg_hit(wb_adr_i, `FPE_OFS_CTRL) && key_ok
                    && req_cmd != '0) begin
                    state_nxt = FPE_RUN;
                    cmd_nxt   = req_cmd;
                    start_nxt = 1'b1;
                    // misaligned input is a software fault; low bits
                    // are simply dropped
                    if (req_cmd[`FPE_CMD_PERASE]) begin
                        op_addr_nxt = align_down(addr_r,
                                                 `FPE_PAGE_ALIGN_B);
                    end else begin
                        op_addr_nxt = align_down(addr_r,
                                                 `FPE_WORD_ALIGN_B);
                    end
                    // erases never look at the data word
                    op_data_nxt = req_cmd[`FPE_CMD_PROG] ? data_r
                                                         : `FPE_RST_WORD;
                end
            end
            FPE_RUN: begin
                // control writes are dropped until completion
                if (op_done) begin
                    state_nxt = FPE_IDLE;
                    cmd_nxt   = '0;  // busy bit reads zero again
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_r   <= FPE_IDLE;
            cmd_r     <= '0;
            start_r   <= 1'b0;
            op_addr_r <= 15'h0000;
            op_data_r <= `FPE_RST_WORD;
        end else begin
            state_r   <= state_nxt;
            cmd_r     <= cmd_nxt;
            start_r   <= start_nxt;
            op_addr_r <= op_addr_nxt;
            op_data_r <= op_data_nxt;
        end
    end

    // the pulse length is only right if software keeps the reload equal
    // to the clock in MHz minus one while busy
    fpe_usec_tick fpe_usec_tick_inst (
        .sys_clk (sys_clk),
        .reset   (reset),
        .run     (state_r == FPE_RUN),
        .reload  (microsecond_tick_reload),
        .tick    (tick)
    );

    // timer is loaded by the launch pulse, when cmd_r already holds it
    fpe_op_timer #(
        .CNT_W (CNT_W)
    ) fpe_op_timer_inst (
        .sys_clk (sys_clk),
        .reset   (reset),
        .start   (start_r),
        .dur_us  (dur_us),
        .tick    (tick),
        .done    (op_done)
    );

    assign flash_op_sel   = cmd_r;
    assign flash_op_start = start_r;
    assign flash_op_addr  = op_addr_r;
    assign flash_op_data  = op_data_r;
    assign flash_busy     = (state_r == FPE_RUN);

    // ---------------------------------------------------------------
    // interrupt status: read clears, but a new event in the same cycle
    // wins so that it is never lost
    // ---------------------------------------------------------------
    always_comb begin
        stat_nxt = stat_r;
        if (rd_acc && reg_hit(wb_adr_i, `FPE_OFS_STAT)) begin
            stat_nxt = 2'h0;
        end
        if (op_done && !cmd_r[`FPE_CMD_COMMIT]) begin
            stat_nxt[`FPE_ST_PROG] = 1'b1;
        end
        if (access_violation) begin
            stat_nxt[`FPE_ST_ACCESS] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stat_r <= 2'h0;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    assign program_done_raw_flag = stat_r[`FPE_ST_PROG];
    assign irq                   = |(stat_r & mask_r);

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    ack_one_cycle_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");

    bad_key_ignored_a: assert property (
        wr_acc && reg_hit(wb_adr_i, `FPE_OFS_CTRL) && !key_ok
        && state_r == FPE_IDLE |=> cmd_r == '0 && !start_r)
        else $error("control write without key started a command");

    key_reads_zero_a: assert property (
        wb_ack_o && !wb_we_i && reg_hit(wb_adr_i, `FPE_OFS_CTRL)
        |-> wb_dat_o[31:16] == 16'h0000)
        else $error("key field read back nonzero");

    addr_upper_zero_a: assert property (
        wb_ack_o && !wb_we_i && reg_hit(wb_adr_i, `FPE_OFS_ADDR)
        |-> wb_dat_o[31:15] == 17'h0 && wb_dat_o[14:0] == addr_r)
        else $error("address register readback wrong");

    prog_start_a: assert property (
        wr_acc && reg_hit(wb_adr_i, `FPE_OFS_CTRL) && key_ok
        && state_r == FPE_IDLE && wb_dat_i[3:0] == 4'h1
        |=> start_r && cmd_r == 4'h1 && flash_op_data == $past(data_r))
        else $error("keyed program write did not launch");

    busy_held_a: assert property (
        state_r == FPE_RUN && !op_done |=> $stable(cmd_r) && cmd_r != '0)
        else $error("busy bit changed before completion");

    word_align_a: assert property (
        start_r && cmd_r[`FPE_CMD_PROG] |-> flash_op_addr[1:0] == 2'h0)
        else $error("program address not word aligned");

    page_align_a: assert property (
        start_r && cmd_r[`FPE_CMD_PERASE] |-> flash_op_addr[9:0] == 10'h0)
        else $error("page erase address not page aligned");

    done_flag_a: assert property (
        op_done && !cmd_r[`FPE_CMD_COMMIT] |=> program_done_raw_flag
        ##0 cmd_r == '0)
        else $error("completion did not raise done flag");

    commit_no_flag_a: assert property (
        op_done && cmd_r[`FPE_CMD_COMMIT] && !stat_r[`FPE_ST_PROG]
        |=> !stat_r[`FPE_ST_PROG] && cmd_r == '0)
        else $error("commit completion misreported");
endmodule : fpe_flash_ctrl

//--- test_fpe_flash_ctrl.sv
// self-checking testbench of the flash program and erase controller
`timescale 1ns/10ps
`include "fpe_defines.svh"
module test_fpe_flash_ctrl;
    import fpe_pkg::*;
    localparam int RL = 39;                 // tick reload: clock MHz minus one
    logic              sys_clk;             // 40 MHz system clock
    logic              reset;               // async, active high
    logic              wb_cyc_i;            // bus cycle
    logic              wb_stb_i;            // bus strobe
    logic              wb_we_i;             // bus write
    logic       [11:0] wb_adr_i;            // byte address
    logic       [3:0]  wb_sel_i;            // byte enables
    logic       [31:0] wb_dat_i;            // write data
    logic       [31:0] wb_dat_o;            // read data
    logic              wb_ack_o;            // bus acknowledge
    logic       [7:0]  microsecond_tick_reload;
    logic              access_violation;    // protection fault pulse
    logic              exec_only_read;      // execute-only read level
    fpe_cmd_t          flash_op_sel;        // running command
    logic              flash_op_start;      // launch pulse
    logic       [14:0] flash_op_addr;       // target address
    logic       [31:0] flash_op_data;       // program word
    logic              flash_busy;          // operation running
    logic              program_done_raw_flag;
    logic              irq;                 // level interrupt
    int                n_fail;              // mismatches
    int                comparisons;         // comparisons made
    int                cyc_n;               // free cycle count
    logic       [31:0] q;                   // scratch read value

    // shortened operation times so the run stays short
    fpe_flash_ctrl #(.PROG_US(6), .PERASE_US(8), .MASS_US(10),
                     .COMMIT_US(6)) fpe_flash_ctrl_inst (
        .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .microsecond_tick_reload(microsecond_tick_reload),
        .access_violation(access_violation),
        .exec_only_read(exec_only_read), .flash_op_sel(flash_op_sel),
        .flash_op_start(flash_op_start), .flash_op_addr(flash_op_addr),
        .flash_op_data(flash_op_data), .flash_busy(flash_busy),
        .program_done_raw_flag(program_done_raw_flag), .irq(irq));

    // clock generator, 25 ns period
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // cycle counter used to time operations
    always @(posedge sys_clk) begin
        cyc_n <= cyc_n + 1;
    end

    task automatic complete_run;
        if (n_fail == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; waits for ack under a bound, idle cycle first
    task automatic xfer(input logic we, input logic [11:0] adr,
                        input logic [31:0] dat);
        int n;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= 4'hf;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            complete_run();
        end
    endtask : xfer

    // expected readback of the control register for one command
    function automatic logic [31:0] cmd_word(input int i);
        return 32'h1 << i;
    endfunction : cmd_word

    // one keyed command: refused key, start, ignored writes, completion
    task automatic run_op(input int i, input int dur);
        logic [14:0] a;
        logic [31:0] d;
        logic [15:0] k;
        int          t0;
        // page erases get a 1 KB aligned address, the rest word aligned
        a = 15'($urandom) & ((i == 1) ? 15'h7c00 : 15'h7ffc);
        d = $urandom;
        k = 16'($urandom);
        if (k == `FPE_WRITE_KEY) k = ~k;
        xfer(1'b1, `FPE_OFS_ADDR, {17'h0, a});
        xfer(1'b1, `FPE_OFS_DATA, d);
        xfer(1'b1, `FPE_OFS_CTRL, {k, 12'h0, 4'(cmd_word(i))});
        repeat (3) @(posedge sys_clk);
        #1;
        chk(flash_busy, 1'b0);
        xfer(1'b1, `FPE_OFS_CTRL, {`FPE_WRITE_KEY, 12'h0, 4'(cmd_word(i))});
        #1;
        for (int n = 0; n < 3 && flash_op_start !== 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        t0 = cyc_n;
        chk(flash_op_start, 1'b1);
        chk(flash_op_sel, cmd_word(i));
        if (i < 2) chk(flash_op_addr, a);
        if (i < 3) chk(flash_op_data, (i == 0) ? d : 32'h0);
        xfer(1'b1, `FPE_OFS_CTRL, {`FPE_WRITE_KEY, 16'h0});
        xfer(1'b1, `FPE_OFS_CTRL, {`FPE_WRITE_KEY, 12'h0,
                                   4'(cmd_word((i + 1) % 4))});
        xfer(1'b0, `FPE_OFS_CTRL, 32'h0);
        chk(q, cmd_word(i));
        chk(flash_op_sel, cmd_word(i));
        while (flash_busy === 1'b1 && cyc_n - t0 < 500) begin
            @(posedge sys_clk);
            #1;
        end
        // a hung operation ends the run at once
        if (flash_busy !== 1'b0) begin
            n_fail++;
            complete_run();
        end
        // busy lasts the full time: dur us at RL+1 cycles each
        chk(cyc_n - t0 >= dur * (RL + 1), 1'b1);
        chk(cyc_n - t0 <= dur * (RL + 1) + 4, 1'b1);
        chk(program_done_raw_flag, i < 3);
        chk(irq, i < 3);
        xfer(1'b0, `FPE_OFS_CTRL, 32'h0);
        chk(q, 32'h0);
        xfer(1'b0, `FPE_OFS_STAT, 32'h0);
        chk(q, (i < 3) ? 32'h2 : 32'h0);
        #1;
        chk(irq, 1'b0);
    endtask : run_op

    // main sequence
    initial begin
        reset = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 12'h000;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        microsecond_tick_reload = 8'(RL);
        access_violation = 1'b0;
        exec_only_read = 1'b0;
        n_fail = 0;
        comparisons = 0;
        cyc_n = 0;
        void'($urandom(32'h2dc63bee));
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        // reset values of every register, then the unmapped hole
        for (int r = 0; r < 5; r++) begin
            xfer(1'b0, 12'(4 * r), 32'h0);
            chk(q, `FPE_RST_WORD);
        end
        xfer(1'b1, 12'h020, 32'hffff_ffff);
        xfer(1'b0, 12'h020, 32'h0);
        chk(q, 32'h0);
        xfer(1'b1, `FPE_OFS_ADDR, 32'hffff_ffff);
        xfer(1'b0, `FPE_OFS_ADDR, 32'h0);
        chk(q, 32'h0000_7fff);
        xfer(1'b1, `FPE_OFS_DATA, 32'h5a5a_a5a5);
        xfer(1'b0, `FPE_OFS_DATA, 32'h0);
        chk(q, 32'h5a5a_a5a5);
        exec_only_read <= 1'b1;
        xfer(1'b0, `FPE_OFS_DATA, 32'h0);
        chk(q, 32'h0);
        exec_only_read <= 1'b0;
        xfer(1'b1, `FPE_OFS_MASK, 32'h2);
        // each command twice with fresh random address and data
        for (int r = 0; r < 8; r++) begin
            run_op(r % 4, (r % 4 == 1) ? 8 : (r % 4 == 2) ? 10 : 6);
        end
        // access fault: recorded while masked, raised once unmasked
        xfer(1'b1, `FPE_OFS_MASK, 32'h0);
        access_violation <= 1'b1;
        @(posedge sys_clk);
        access_violation <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(irq, 1'b0);
        xfer(1'b1, `FPE_OFS_MASK, 32'h1);
        #1;
        chk(irq, 1'b1);
        xfer(1'b0, `FPE_OFS_STAT, 32'h0);
        chk(q, 32'h1);
        #1;
        chk(irq, 1'b0);
        xfer(1'b0, `FPE_OFS_MASK, 32'h0);
        chk(q, 32'h1);
        complete_run();
    end
endmodule : test_fpe_flash_ctrl
